/* stm16_line_src.sv */
// partner model: line-side STM-16 receive source and tributary source
`timescale 1ns/10ps
`default_nettype none
module stm16_line_src (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_gap,
  input  wire logic       i_lose,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_en,
  output logic            o_rx_fp,
  output logic            o_rx_in_frame,
  output logic      [7:0] o_add_data,
  output logic            o_add_en,
  output logic            o_add_fp
);
  // ******************************************************************
  // byte position within a 9 x 4320 frame
  // ******************************************************************
  logic [15:0] pos_q;
  logic [15:0] pos_d;
  logic        ph_q;
  logic [7:0]  rx_v;
  logic [7:0]  add_v;
  logic        first_w;
  // a gapped source ticks every other cycle, the slow case
  assign o_rx_en       = ~(i_gap & ph_q);
  assign o_add_en      = o_rx_en;
  assign first_w       = (pos_q == 16'h0000);
  assign o_rx_fp       = o_rx_en & first_w;
  assign o_add_fp      = o_rx_fp;
  assign o_rx_in_frame = ~i_lose;
  assign pos_d = (pos_q == 16'h97df) ? 16'h0000 : pos_q + 16'h0001;
  // framing bytes are real so a framed receiver makes sense
  assign rx_v  = (pos_q < 16'h0030) ? 8'hf6 :
                 (pos_q < 16'h0060) ? 8'h28 : pos_q[7:0] ^ pos_q[15:8];
  assign add_v = pos_q[11:4] ^ 8'h5a;
  // between ticks the lines carry the inverse so stale data cannot pass
  assign o_rx_data  = o_rx_en ? rx_v : ~rx_v;
  assign o_add_data = o_add_en ? add_v : ~add_v;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_q <= 16'h0000;
      ph_q  <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      if (o_rx_en) begin
        pos_q <= pos_d;
      end
    end
  end
endmodule
`default_nettype wire

/* stm16_pattern_gen.sv */
// test-pattern byte generator, all-zeros and PN23/PN31 with inversion
`timescale 1ns/10ps
`default_nettype none
module stm16_pattern_gen
  import stm16_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_adv,
  input  wire logic [2:0] i_sel,
  output logic      [7:0] o_byte
);
  logic [22:0] s23_q;
  logic [30:0] s31_q;
  logic [22:0] n23;
  logic [30:0] n31;
  logic [7:0]  b23;
  logic [7:0]  b31;

  // eight serial steps per byte, msb first
  always_comb begin
    n23 = s23_q;
    n31 = s31_q;
    b23 = 8'h00;
    b31 = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b23[7-i] = n23[22] ^ n23[17];
      n23      = {n23[21:0], b23[7-i]};
      b31[7-i] = n31[30] ^ n31[27];
      n31      = {n31[29:0], b31[7-i]};
    end
  end

  // both registers only step on payload bytes, so the sequence
  // continues seamlessly across overhead and frame boundaries
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s23_q <= '1;
      s31_q <= '1;
    end else if (i_adv) begin
      s23_q <= n23;
      s31_q <= n31;
    end
  end

  assign o_byte = (i_sel == PAT_PN23)  ? b23 :
                  (i_sel == PAT_PN23I) ? ~b23 :
                  (i_sel == PAT_PN31)  ? b31 :
                  (i_sel == PAT_PN31I) ? ~b31 : 8'h00;

  a_prbs_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    !i_adv |=> $stable(s23_q) && $stable(s31_q))
    else $error("pattern stepped outside payload");
endmodule
`default_nettype wire

/* stm16_pkg.sv */
// constants for the STM-16 transmit frame builder
// What this block does
// - 155 add modes time output from tributary
// - 155 replicate: sixteen copies of tributary
// - 155 single: one copy, others unequipped
// - 622 add modes time output from tributary
// - 622 replicate: four copies of STM-4
// - 622 single: STM-4 in chosen channel
// - internal: sixteen pattern-filled unequipped channels
// - internal: A1 bytes F6, A2 bytes 28
// - J0 is 1, then numbered 2 to 48
// - internal: H1 is 6A, H2 is 0A
// - compute and insert B1 and B2 parity
// - unassigned overhead bytes default to zero
// - internal timing from one of three references
// - through mode only while receiver in frame
// - through mode copies received payload
// - through keeps overhead, recomputes B1 and B2
// - unequipped VC-4 signal label is zero
package stm16_pkg;
  // ******************************************************************
  // frame geometry, byte-interleaved STM-16
  // ******************************************************************
  localparam logic [12:0] COL_LAST = 13'h10df;
  localparam logic [3:0]  ROW_LAST = 4'h8;
  localparam logic [12:0] COL_1X   = 13'h0010;
  localparam logic [12:0] COL_3X   = 13'h0030;
  localparam logic [12:0] COL_4X   = 13'h0040;
  localparam logic [12:0] COL_6X   = 13'h0060;
  localparam logic [12:0] COL_9X   = 13'h0090;
  localparam logic [12:0] NU_BIAS  = 13'h005f;
  localparam logic [8:0]  SUB_POH  = 9'h009;
  localparam logic [3:0]  ROW_B1   = 4'h1;
  localparam logic [3:0]  ROW_RS   = 4'h2;
  localparam logic [3:0]  ROW_PTR  = 4'h3;
  localparam logic [3:0]  ROW_B2   = 4'h4;
  localparam int          NB2      = 48;
  // ******************************************************************
  // overhead values
  // ******************************************************************
  localparam logic [7:0] A1_VAL  = 8'hf6;
  localparam logic [7:0] A2_VAL  = 8'h28;
  localparam logic [7:0] J0_VAL  = 8'h01;
  localparam logic [7:0] NU_LAST = 8'h30;
  localparam logic [7:0] H1_VAL  = 8'h6a;
  localparam logic [7:0] H2_VAL  = 8'h0a;
  localparam logic [7:0] H1_CC   = 8'h9b;
  localparam logic [7:0] H2_CC   = 8'hff;
  localparam logic [7:0] OH_DEF  = 8'h00;
  localparam logic [7:0] C2_UNEQ = 8'h00;
  // ******************************************************************
  // modes, patterns, timing references
  // ******************************************************************
  localparam logic [2:0] MODE_INT  = 3'h0;
  localparam logic [2:0] MODE_A1A  = 3'h1;
  localparam logic [2:0] MODE_A1O  = 3'h2;
  localparam logic [2:0] MODE_A4A  = 3'h3;
  localparam logic [2:0] MODE_A4O  = 3'h4;
  localparam logic [2:0] MODE_THRU = 3'h5;
  localparam logic [2:0] PAT_ZERO  = 3'h0;
  localparam logic [2:0] PAT_PN23  = 3'h1;
  localparam logic [2:0] PAT_PN23I = 3'h2;
  localparam logic [2:0] PAT_PN31  = 3'h3;
  localparam logic [2:0] PAT_PN31I = 3'h4;
  localparam logic [1:0] TREF_OSC  = 2'h0;
  localparam logic [1:0] TREF_BITS = 2'h1;
  localparam logic [1:0] TREF_SETS = 2'h2;
  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int CT_MODE = 0;
  localparam int CT_PAT  = 4;
  localparam int CT_CHAN = 8;
  localparam int CT_TREF = 12;
endpackage

/* stm16_tx_frame_builder.sv */
// STM-16 transmit frame builder with APB control
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module stm16_tx_frame_builder
  import stm16_pkg::*;
#(
  parameter int INT_DIV = 1
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [7:0]  i_add_data,
  input  wire logic        i_add_en,
  input  wire logic        i_add_fp,
  output logic             o_add_take,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_en,
  input  wire logic        i_rx_fp,
  input  wire logic        i_rx_in_frame,
  input  wire logic        i_bits_clk,
  input  wire logic        i_sets_clk,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_en,
  output logic             o_tx_fp,
  output logic             o_thru_active
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  // ******************************************************************
  // registers and control fields
  // ******************************************************************
  logic [15:0] ctrl_q;
  logic [2:0]  act_mode_q;
  logic [2:0]  act_pat_q;
  logic [3:0]  act_chan_q;
  logic [15:0] fcnt_q;
  logic        thru_act_q;
  logic [31:0] rdata_q;

  wire [2:0] req_mode = ctrl_q[CT_MODE +: 3];
  wire [2:0] req_pat  = ctrl_q[CT_PAT +: 3];
  wire [3:0] req_chan = ctrl_q[CT_CHAN +: 4];
  wire [1:0] req_tref = ctrl_q[CT_TREF +: 2];
  // ******************************************************************
  // timing references
  // ******************************************************************
  logic [1:0] ref_s1_q;
  logic [1:0] ref_s2_q;
  logic [1:0] ref_s3_q;
  logic [7:0] div_q;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_s1_q <= 2'h0;
      ref_s2_q <= 2'h0;
      ref_s3_q <= 2'h0;
    end else begin
      ref_s1_q <= {i_sets_clk, i_bits_clk};
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  // an external reference realigns the byte divider on each rising edge
  wire bits_edge = ref_s2_q[0] & ~ref_s3_q[0];
  wire sets_edge = ref_s2_q[1] & ~ref_s3_q[1];
  wire ref_edge  = (req_tref == TREF_BITS) ? bits_edge :
                   (req_tref == TREF_SETS) ? sets_edge : 1'b0;
  wire int_tick  = (div_q == 8'(INT_DIV - 1));
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) div_q <= 8'h00;
    else if (int_tick || ref_edge) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  // ******************************************************************
  // byte timing and frame position
  // ******************************************************************
  wire m_int  = (act_mode_q == MODE_INT);
  wire m_a1a  = (act_mode_q == MODE_A1A);
  wire m_a1o  = (act_mode_q == MODE_A1O);
  wire m_a4a  = (act_mode_q == MODE_A4A);
  wire m_a4o  = (act_mode_q == MODE_A4O);
  wire m_thru = (act_mode_q == MODE_THRU);
  wire m_add  = m_a1a | m_a1o | m_a4a | m_a4o;
  // add modes run on the tributary byte rate, so no pointer moves
  wire tick  = m_thru ? i_rx_en : m_add ? i_add_en : int_tick;
  wire fsync = m_thru ? i_rx_fp : m_add ? i_add_fp : 1'b0;
  logic [12:0] col_q;
  logic [3:0]  row_q;
  logic [1:0]  m3_q;
  wire        resync = tick & fsync;
  wire [12:0] col_c  = resync ? 13'h0000 : col_q;
  wire [3:0]  row_c  = resync ? 4'h0 : row_q;
  wire [1:0]  m3_c   = resync ? 2'h0 : m3_q;
  wire [3:0]  ch     = col_c[3:0];
  wire [8:0]  sub    = col_c[12:4];
  wire        fstart = tick && col_c == 13'h0000 && row_c == 4'h0;
  wire        is_oh  = sub < SUB_POH;
  wire        is_poh = sub == SUB_POH;
  wire        is_pay = sub > SUB_POH;
  wire        eol    = col_c == COL_LAST;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      col_q <= 13'h0000;
      row_q <= 4'h0;
      m3_q  <= 2'h0;
    end else if (tick) begin
      col_q <= eol ? 13'h0000 : col_c + 13'h0001;
      if (eol) row_q <= (row_c == ROW_LAST) ? 4'h0 : row_c + 4'h1;
      else row_q <= row_c;
      if (ch == 4'hf) m3_q <= (m3_c == 2'h2) ? 2'h0 : m3_c + 2'h1;
      else m3_q <= m3_c;
    end
  end

  // ******************************************************************
  // mode latch at frame boundary
  // ******************************************************************
  wire       mode_ok  = req_mode <= MODE_THRU;
  wire [2:0] eff_mode = (!mode_ok ||
                        (req_mode == MODE_THRU && !i_rx_in_frame)) ?
                        MODE_INT : req_mode;
  // 155 single-channel fill offers only the PN23 family
  wire       pn31_req = req_pat == PAT_PN31 || req_pat == PAT_PN31I;
  wire [2:0] eff_pat  = (req_pat > PAT_PN31I) ? PAT_ZERO :
                        (eff_mode == MODE_A1O && pn31_req) ?
                        req_pat - 3'h2 : req_pat;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      act_mode_q <= MODE_INT;
      act_pat_q  <= PAT_ZERO;
      act_chan_q <= 4'h0;
      fcnt_q     <= 16'h0000;
      thru_act_q <= 1'b0;
    end else begin
      thru_act_q <= m_thru && i_rx_in_frame;
      if (fstart) begin
        act_mode_q <= eff_mode;
        act_pat_q  <= eff_pat;
        act_chan_q <= req_chan;
        fcnt_q     <= fcnt_q + 16'h0001;
      end else if (m_thru && !i_rx_in_frame) begin
        act_mode_q <= MODE_INT;
      end
    end
  end

  // ******************************************************************
  // channel sourcing
  // ******************************************************************
  wire gen_ch = m_int | (m_a1o && ch != act_chan_q) |
                (m_a4o && ch[1:0] != act_chan_q[1:0]);
  // one tributary byte feeds every replica that follows it
  wire take = (m_a1a && ch == 4'h0) | (m_a1o && ch == act_chan_q) |
              (m_a4a && ch[1:0] == 2'h0) |
              (m_a4o && ch[1:0] == act_chan_q[1:0]);
  logic [7:0] trib_q;
  wire  [7:0] add_byte = take ? i_add_data : trib_q;
  assign o_add_take = tick && take;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) trib_q <= 8'h00;
    else if (o_add_take) trib_q <= i_add_data;
  end

  // ******************************************************************
  // generated overhead and payload
  // ******************************************************************
  wire [7:0] nu_val = 8'(col_c - NU_BIAS);
  wire       nu_pos = row_c == 4'h0 && col_c >= COL_6X && col_c < COL_9X;
  wire [7:0] pat_byte;
  logic [7:0] oh_byte;
  always_comb begin
    oh_byte = OH_DEF;
    if (row_c == 4'h0) begin
      if (col_c < COL_3X) oh_byte = A1_VAL;
      else if (col_c < COL_6X) oh_byte = A2_VAL;
      else oh_byte = nu_val;
    end else if (row_c == ROW_PTR) begin
      if (col_c < COL_1X) oh_byte = H1_VAL;
      else if (col_c < COL_3X) oh_byte = H1_CC;
      else if (col_c < COL_4X) oh_byte = H2_VAL;
      else if (col_c < COL_6X) oh_byte = H2_CC;
    end
  end

  // the path overhead column stays zero, so C2 reads unequipped
  wire [7:0] gen_byte = is_oh ? oh_byte :
                        is_pay ? pat_byte : C2_UNEQ;
  stm16_pattern_gen u_pat (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_adv  (tick && gen_ch && is_pay),
    .i_sel  (act_pat_q),
    .o_byte (pat_byte)
  );

  wire [7:0] base = m_thru ? i_rx_data :
                    gen_ch ? gen_byte :
                    nu_pos ? nu_val : add_byte;

  // ******************************************************************
  // parity: B1 over whole frame, B2 per channel and lane
  // ******************************************************************
  logic [7:0] b1_acc_q;
  logic [7:0] b1_q;
  logic [7:0] b2_acc [NB2];
  logic [7:0] b2_hold [NB2];
  logic [7:0] byte_d;

  wire [5:0] b2_idx = {m3_c, ch};
  wire       b2_cov = !(row_c <= ROW_RS && is_oh);
  wire       b1_pos = row_c == ROW_B1 && col_c == 13'h0000;
  wire       b2_pos = row_c == ROW_B2 && col_c < COL_3X;
  assign byte_d = b1_pos ? b1_q :
                  b2_pos ? b2_hold[col_c[5:0]] : base;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      b1_acc_q <= 8'h00;
      b1_q     <= 8'h00;
    end else if (fstart) begin
      b1_acc_q <= byte_d;
      b1_q     <= b1_acc_q;
    end else if (tick) begin
      b1_acc_q <= b1_acc_q ^ byte_d;
    end
  end

  for (genvar k = 0; k < NB2; k++) begin : g_b2
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        b2_acc[k]  <= 8'h00;
        b2_hold[k] <= 8'h00;
      end else if (fstart) begin
        b2_acc[k]  <= 8'h00;
        b2_hold[k] <= b2_acc[k];
      end else if (tick && b2_cov && b2_idx == 6'(k)) begin
        b2_acc[k] <= b2_acc[k] ^ byte_d;
      end
    end
  end

  // ******************************************************************
  // output stage
  // ******************************************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_data <= 8'h00;
      o_tx_en   <= 1'b0;
      o_tx_fp   <= 1'b0;
    end else begin
      o_tx_en <= tick;
      o_tx_fp <= fstart;
      if (tick) o_tx_data <= byte_d;
    end
  end

  assign o_thru_active = thru_act_q;

  // ******************************************************************
  // APB slave, zero wait states
  // ******************************************************************
  wire ap_setup = i_psel && !i_penable;
  wire ap_acc   = i_psel && i_penable;
  wire hit_ctrl = i_paddr == CTRL_OFS;
  wire hit_stat = i_paddr == STAT_OFS;
  // status: frame count, thru, channel, rx frame, pattern, mode
  wire [31:0] stat_w = {fcnt_q, 3'h0, thru_act_q, act_chan_q,
                        i_rx_in_frame, act_pat_q, 1'b0, act_mode_q};

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q  <= CTRL_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (ap_setup)
        rdata_q <= hit_ctrl ? {16'h0000, ctrl_q} :
                   hit_stat ? stat_w : 32'h0000_0000;
      if (ap_acc && i_pwrite && hit_ctrl) ctrl_q <= i_pwdata[15:0];
    end
  end

  assign o_prdata  = rdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = ap_acc && !(hit_ctrl || hit_stat);

  // ******************************************************************
  // assertions
  // ******************************************************************
  a_a1_fill: assert property (
    tick && m_int && row_c == 4'h0 && col_c < COL_3X
    |=> o_tx_data == A1_VAL) else $error("A1 byte wrong");
  a_a2_fill: assert property (
    tick && m_int && row_c == 4'h0 && col_c >= COL_3X && col_c < COL_6X
    |=> o_tx_data == A2_VAL) else $error("A2 byte wrong");
  a_j0_number: assert property (
    tick && !m_thru && row_c == 4'h0 && col_c == COL_6X
    |=> o_tx_data == J0_VAL ##0 $past(col_c) == COL_6X)
    else $error("J0 not one");
  a_nu_last: assert property (
    tick && !m_thru && row_c == 4'h0 && col_c == COL_9X - 13'h0001
    |=> o_tx_data == NU_LAST) else $error("numbering not ending at 48");
  a_h1_ptr: assert property (
    tick && m_int && row_c == ROW_PTR && col_c < COL_1X
    |=> o_tx_data == H1_VAL) else $error("H1 wrong");
  a_b1_insert: assert property (
    tick && b1_pos |=> o_tx_en && o_tx_data == $past(b1_q))
    else $error("B1 not inserted");
  a_b2_insert: assert property (
    tick && row_c == ROW_B2 && col_c == 13'h0000
    |=> o_tx_data == $past(b2_hold[0])) else $error("B2 not inserted");
  a_thru_copy: assert property (
    tick && m_thru && is_pay |=> o_tx_data == $past(i_rx_data))
    else $error("through payload not copied");
  a_thru_gate: assert property (
    !i_rx_in_frame |=> !o_thru_active && !m_thru)
    else $error("through mode without frame");
  a_poh_zero: assert property (
    tick && gen_ch && is_poh |=> o_tx_data == C2_UNEQ)
    else $error("unequipped path overhead not zero");
  a_chan_hold: assert property (!fstart && !(m_thru && !i_rx_in_frame)
    |=> $stable(act_chan_q) && $stable(act_mode_q))
    else $error("selection changed mid-frame");
  a_rep_copy: assert property (
    tick && (m_a1a || m_a4a) && is_pay && !take
    |=> o_tx_data == $past(trib_q)) else $error("replica mismatch");
  a_add_timing: assert property (
    m_add && !i_add_en |=> !o_tx_en) else $error("add timing lost");
endmodule
`default_nettype wire

/* stm16_tx_frame_builder_bench.sv */
// self-checking bench for the STM-16 transmit frame builder
`timescale 1ns/10ps
`default_nettype none
module stm16_tx_frame_builder_bench;
  import stm16_pkg::*;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic        i_mclk, i_rstn, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic        o_pready, o_pslverr, i_add_en, i_add_fp, o_add_take;
  logic [7:0]  i_add_data, i_rx_data, o_tx_data;
  logic        i_rx_en, i_rx_fp, i_rx_in_frame, i_bits_clk, i_sets_clk;
  logic        o_tx_en, o_tx_fp, o_thru_active, i_gap, i_lose;
  int          fail_count, checked, cyc, fnum, pos, i;
  logic [7:0]  xr;
  logic [7:0]  bpar [0:2];
  logic [7:0]  fr [0:2][0:38879];
  stm16_tx_frame_builder #(.INT_DIV(1)) i_stm16_tx_frame_builder (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_add_data(i_add_data), .i_add_en(i_add_en),
    .i_add_fp(i_add_fp), .o_add_take(o_add_take), .i_rx_data(i_rx_data),
    .i_rx_en(i_rx_en), .i_rx_fp(i_rx_fp), .i_rx_in_frame(i_rx_in_frame),
    .i_bits_clk(i_bits_clk), .i_sets_clk(i_sets_clk),
    .o_tx_data(o_tx_data), .o_tx_en(o_tx_en), .o_tx_fp(o_tx_fp),
    .o_thru_active(o_thru_active));
  stm16_line_src i_stm16_line_src (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_gap(i_gap), .i_lose(i_lose),
    .o_rx_data(i_rx_data), .o_rx_en(i_rx_en), .o_rx_fp(i_rx_fp),
    .o_rx_in_frame(i_rx_in_frame), .o_add_data(i_add_data),
    .o_add_en(i_add_en), .o_add_fp(i_add_fp));
  always #4 i_mclk = ~i_mclk;
  // ******************************************************************
  // frame monitor: stores three frames and the running xor before each
  // ******************************************************************
  always @(posedge i_mclk) begin
    if (o_tx_en === 1'b1) begin
      if (o_tx_fp === 1'b1) begin
        fnum++;
        pos = 0;
        if (fnum < 3) bpar[fnum] = xr;
        xr = 8'h00;
      end
      if (fnum >= 0 && fnum < 3 && pos < 38880) fr[fnum][pos] = o_tx_data;
      xr = xr ^ o_tx_data;
      pos++;
    end
  end
  // ******************************************************************
  // shared tasks
  // ******************************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a hang ends here; the full run needs about 82000 cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic chb(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    chk(nm, {24'h00_0000, e}, {24'h00_0000, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1) @(posedge i_mclk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic wait_at(input int f, input int p);
    while (fnum < f || (fnum == f && pos < p)) @(posedge i_mclk);
  endtask
  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, CTRL_OFS, 32'h0000_0000, rd, er);
    chk("ctrl reset", {16'h0000, CTRL_RST}, rd);
    apb(1'b0, 12'h008, 32'h0000_0000, rd, er);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'b1, CTRL_OFS, {29'h0000_0000, MODE_THRU}, rd, er);
    apb(1'b0, CTRL_OFS, 32'h0000_0000, rd, er);
    chk("ctrl readback", {29'h0000_0000, MODE_THRU}, rd);
    apb(1'b0, STAT_OFS, 32'h0000_0000, rd, er);
    chk("status framed", 32'h0000_0001, {31'h0000_0000, rd[7]});
    $display("test regs done");
  endtask
  task automatic t_internal();
    wait_at(1, 0);
    for (i = 0; i < 48; i++) begin
      chb("a1 byte", 8'hf6, fr[0][i]);
      chb("a2 byte", 8'h28, fr[0][48 + i]);
    end
    chb("j0 byte", 8'h01, fr[0][96]);
    for (i = 1; i < 16; i++)
      chb("z0 number", 8'(i + 1), fr[0][96 + i]);
    for (i = 0; i < 16; i++) begin
      chb("h1 byte", 8'h6a, fr[0][12960 + i]);
      chb("h2 byte", 8'h0a, fr[0][13008 + i]);
    end
    chb("spare overhead", 8'h00, fr[0][8640]);
    chb("spare overhead", 8'h00, fr[0][25920]);
    chb("signal label", 8'h00, fr[0][8784]);
    chb("zero payload", 8'h00, fr[0][22600]);
    $display("test internal done");
  endtask
  task automatic t_thru();
    logic [31:0] rd;
    logic        er;
    wait_at(1, 200);
    chk("thru live", 32'h0000_0001, {31'h0000_0000, o_thru_active});
    apb(1'b1, CTRL_OFS, {29'h0000_0000, MODE_A1A}, rd, er);
    wait_at(1, 38870);
    i_lose <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk("thru dropped", 32'h0000_0000, {31'h0, o_thru_active});
    i_lose <= 1'b0;
    wait_at(2, 4400);
    chb("kept a1", 8'hf6, fr[1][0]);
    chb("kept j0", 8'h60, fr[1][96]);
    chb("payload", 8'hf5, fr[1][500]);
    chb("payload", 8'h6e, fr[1][20000]);
    chb("thru b1", bpar[1], fr[1][4320]);
    $display("test thru done");
  endtask
  task automatic t_add();
    int n;
    chb("add j0", 8'h01, fr[2][96]);
    for (i = 0; i < 32; i++)
      chb("replica", 8'((160 + i) >> 4) ^ 8'h5a, fr[2][160 + i]);
    chb("add b1", bpar[2], fr[2][4320]);
    // one tributary byte is consumed per sixteen output bytes
    n = 0;
    repeat (160) begin
      @(posedge i_mclk);
      if (o_add_take === 1'b1) n++;
    end
    chk("take count", 32'h0000_000a, 32'(n));
    // a half-rate tributary must halve the output byte rate
    i_gap <= 1'b1;
    repeat (4) @(posedge i_mclk);
    n = 0;
    repeat (100) begin
      @(posedge i_mclk);
      if (o_tx_en === 1'b1) n++;
    end
    chk("byte rate", 32'd50, 32'(n));
    $display("test add done");
  endtask
  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    i_mclk = 1'b0;
    i_rstn = 1'b0;
    {i_psel, i_penable, i_pwrite, i_gap, i_lose} = 5'h00;
    {i_bits_clk, i_sets_clk} = 2'h0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    {fail_count, checked, cyc, pos} = '0;
    fnum = -1;
    xr = 8'h00;
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    t_regs();
    t_internal();
    t_thru();
    t_add();
    finish_test();
  end
endmodule
`default_nettype wire
